// *** core/dcr_dma.sv ***
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module dcr_dma (
    input  wire logic                      ref_clk_in,
    input  wire logic                      reset_n_in,
    input  wire logic [7:0]                addr_in,
    input  wire logic [15:0]               wdata_in,
    input  wire logic                      wr_in,
    input  wire logic                      rd_in,
    output logic [15:0]                    rdata_out,
    input  wire logic [dcr_pkg::NUM_CH-1:0] dreq_in,
    input  wire logic [15:0]               pia_adr_in,
    output dcr_pkg::dcr_xfer_t             xfer_out,
    output logic                           irq_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int unsigned N = dcr_pkg::NUM_CH;

    logic [N-1:0]  req_s1_r;          // Synchroniser stage one
    logic [N-1:0]  req_s2_r;          // Synchroniser stage two
    logic [N-1:0]  req_d_r;           // Delayed for edge detect
    wire  [N-1:0]  req_edge;          // New request per channel
    logic [N-1:0]  pend_r;            // Pending request per channel
    logic [N-1:0]  en_v;              // Channel enables
    wire  [N-1:0]  elig;              // Pending and enabled
    wire  [N-1:0]  gnt;               // One-hot grant
    logic [N-1:0]  sel_r;             // 1 = secondary selected
    logic [N-1:0]  wcol_r;            // Write collision flags
    logic [N-1:0]  rcol_r;            // Request collision flags
    logic [N-1:0]  ist_r;             // Sticky interrupt status
    logic [N-1:0]  ien_r;             // Interrupt enables
    logic [N-1:0]  irq_ev;            // Interrupt events this cycle
    logic [15:0]   last_r;            // Last SRAM address
    logic [dcr_pkg::CH_W-1:0] lca_r;  // Last active channel
    logic [15:0]   rdata_r;           // Read data register
    logic          irq_r;             // Interrupt output register
    dcr_pkg::dcr_xfer_t xfer_r;       // Transfer output register

    dcr_pkg::dcr_ctrl_t       ctrl_r [N]; // channel_control
    logic [7:0]               stah_r [N]; // Primary start high
    logic [15:0]              stal_r [N]; // Primary start low
    logic [7:0]               stbh_r [N]; // Secondary start high
    logic [15:0]              stbl_r [N]; // Secondary start low
    logic [15:0]              pad_r  [N]; // peripheral_address
    logic [15:0]              cnt_r  [N]; // transfer_count
    logic [dcr_pkg::SA_W-1:0] cur_r  [N]; // Current transfer address
    logic [15:0]              done_r [N]; // Elements moved so far
    logic [dcr_pkg::SA_W-1:0] xadr   [N]; // SRAM address of transfer
    logic [15:0]              rd_ch  [N]; // Per-channel read value

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire       shared_hit = addr_in[7];
    wire [4:0] ch_field   = addr_in[7:3];
    wire [2:0] reg_idx    = addr_in[2:0];
    wire       wr_shared  = wr_in && shared_hit;
    wire       wr_iclr    = wr_in && (addr_in == dcr_pkg::OFS_ICLR);
    wire       wr_ien     = wr_in && (addr_in == dcr_pkg::OFS_IEN);

    // ------------------------------------------------------------
    // Request synchroniser and edge detect
    // ------------------------------------------------------------
    // Requests come from outside the clock domain; only stage two
    // feeds the edge detector so stage one can settle.
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            req_s1_r <= '0;
            req_s2_r <= '0;
            req_d_r  <= '0;
        end
        else
        begin
            req_s1_r <= dreq_in;
            req_s2_r <= req_s1_r;
            req_d_r  <= req_s2_r;
        end
    end

    assign req_edge = req_s2_r & ~req_d_r;

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    // Lowest channel number wins; losers stay pending.
    assign elig = pend_r & en_v;
    assign gnt  = elig & (~elig + {{(N-1){1'b0}}, 1'b1});

    // ------------------------------------------------------------
    // Per-channel registers and sequencing
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_ch
            // Write hits for this channel
            wire hit    = wr_in && !shared_hit &&
                          (ch_field == 5'(g));
            wire w_ctrl = hit && (reg_idx == dcr_pkg::OFS_CTRL);
            wire w_stah = hit && (reg_idx == dcr_pkg::OFS_STAH);
            wire w_stal = hit && (reg_idx == dcr_pkg::OFS_STAL);
            wire w_stbh = hit && (reg_idx == dcr_pkg::OFS_STBH);
            wire w_stbl = hit && (reg_idx == dcr_pkg::OFS_STBL);
            wire w_pad  = hit && (reg_idx == dcr_pkg::OFS_PAD);
            wire w_cnt  = hit && (reg_idx == dcr_pkg::OFS_CNT);

            // Masked write keeps reserved bits at zero
            wire [15:0] ctrl_wd = wdata_in & dcr_pkg::CTRL_MASK;
            wire        go      = gnt[g];
            // Count holds elements, so no size scaling here
            wire        last_el = (done_r[g] == cnt_r[g]);
            wire        half_el = (done_r[g] ==
                                   {1'b0, cnt_r[g][15:1]});
            wire        blk_end = go && last_el;
            wire        pp      = ctrl_r[g].mode[1];
            wire        oneshot = ctrl_r[g].mode[0];
            wire        turn_on = w_ctrl && ctrl_wd[15] &&
                                  !ctrl_r[g].en;
            // Start addresses as 24-bit values
            wire [23:0] sta     = {stah_r[g], stal_r[g]};
            wire [23:0] stb     = {stbh_r[g], stbl_r[g]};
            wire [23:0] step    = ctrl_r[g].size ?
                                  dcr_pkg::STEP_BYTE :
                                  dcr_pkg::STEP_WORD;
            // Next selection after a block in ping-pong mode
            wire        sel_nx  = pp ? ~sel_r[g] : sel_r[g];

            assign en_v[g] = ctrl_r[g].en;

            // SRAM address of this channel's transfer
            assign xadr[g] = (ctrl_r[g].addressing_mode == dcr_pkg::AM_PIA) ?
                             {8'h00, pia_adr_in} : cur_r[g];

            // Interrupt at half or full block per control bit
            assign irq_ev[g] = ctrl_r[g].half ?
                               (go && half_el) : blk_end;

            // Secondary read shows live address while in use
            assign rd_ch[g] =
                (reg_idx == dcr_pkg::OFS_CTRL) ? ctrl_r[g] :
                (reg_idx == dcr_pkg::OFS_STAH) ? {8'h00, stah_r[g]} :
                (reg_idx == dcr_pkg::OFS_STAL) ? stal_r[g] :
                (reg_idx == dcr_pkg::OFS_STBH) ?
                    {8'h00, (sel_r[g] && ctrl_r[g].en) ?
                     cur_r[g][23:16] : stbh_r[g]} :
                (reg_idx == dcr_pkg::OFS_STBL) ?
                    ((sel_r[g] && ctrl_r[g].en) ?
                     cur_r[g][15:0] : stbl_r[g]) :
                (reg_idx == dcr_pkg::OFS_PAD)  ? pad_r[g] :
                (reg_idx == dcr_pkg::OFS_CNT)  ? cnt_r[g] : 16'h0000;

            // Setup registers; writes while enabled are not blocked,
            // software is expected to stay off them then.
            always_ff @(posedge ref_clk_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    stah_r[g] <= 8'h00;
                    stal_r[g] <= 16'h0000;
                    stbh_r[g] <= 8'h00;
                    stbl_r[g] <= 16'h0000;
                    pad_r[g]  <= 16'h0000;
                    cnt_r[g]  <= 16'h0000;
                end
                else
                begin
                    if (w_stah) stah_r[g] <= wdata_in[7:0];
                    if (w_stal) stal_r[g] <= wdata_in;
                    if (w_stbh) stbh_r[g] <= wdata_in[7:0];
                    if (w_stbl) stbl_r[g] <= wdata_in;
                    if (w_pad)  pad_r[g]  <= wdata_in;
                    if (w_cnt)  cnt_r[g]  <= wdata_in;
                end
            end

            // Control word; one-shot drops enable at block end, in ping-pong only after the secondary block
            always_ff @(posedge ref_clk_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                    ctrl_r[g] <= dcr_pkg::CTRL_RST;
                else if (w_ctrl)
                    ctrl_r[g] <= ctrl_wd;
                else if (blk_end && oneshot && (!pp || sel_r[g]))
                    ctrl_r[g].en <= 1'b0;
            end

            // Address and element counter sequencing
            always_ff @(posedge ref_clk_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    cur_r[g]  <= 24'h000000;
                    done_r[g] <= 16'h0000;
                    sel_r[g]  <= 1'b0;
                end
                else if (turn_on)
                begin
                    // Enable starts from the primary buffer
                    cur_r[g]  <= sta;
                    done_r[g] <= 16'h0000;
                    sel_r[g]  <= 1'b0;
                end
                else if (blk_end)
                begin
                    // Reload for next block, swapping in ping-pong
                    cur_r[g]  <= sel_nx ? stb : sta;
                    done_r[g] <= 16'h0000;
                    sel_r[g]  <= sel_nx;
                end
                else if (go)
                begin
                    done_r[g] <= done_r[g] + 16'h0001;
                    if (ctrl_r[g].addressing_mode == dcr_pkg::AM_INC)
                        cur_r[g] <= cur_r[g] + step;
                end
            end

            // Pending and collision flags; a new request wins
            always_ff @(posedge ref_clk_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    pend_r[g] <= 1'b0;
                    rcol_r[g] <= 1'b0;
                    wcol_r[g] <= 1'b0;
                end
                else
                begin
                    pend_r[g] <= (pend_r[g] && !go && ctrl_r[g].en) ||
                                 req_edge[g];
                    // Request still unserved when another arrives
                    if (req_edge[g] && pend_r[g] && !go)
                        rcol_r[g] <= 1'b1;
                    else if (turn_on)
                        rcol_r[g] <= 1'b0;
                    // Request lands on a peripheral write in flight
                    if (req_edge[g] && go &&
                        (ctrl_r[g].dir || ctrl_r[g].null_write_enable))
                        wcol_r[g] <= 1'b1;
                    else if (turn_on)
                        wcol_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Granted channel index and transfer fields
    // ------------------------------------------------------------
    logic [dcr_pkg::CH_W-1:0] gidx;       // Index of granted channel
    always_comb
    begin
        gidx = '0;
        for (int i = N - 1; i >= 0; i--)
            if (gnt[i])
                gidx = dcr_pkg::CH_W'(i);
    end

    wire                any_gnt = |gnt;
    dcr_pkg::dcr_ctrl_t gctrl;            // Control of granted channel
    assign gctrl = ctrl_r[gidx];

    // ------------------------------------------------------------
    // Transfer output and shared status
    // ------------------------------------------------------------
    // The transfer is registered so the outputs come from flops;
    // the SRAM side therefore sees each access one cycle late.
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            xfer_r <= '0;
            last_r <= dcr_pkg::LAST_RST;
            lca_r  <= '0;
        end
        else
        begin
            xfer_r.valid    <= any_gnt;
            xfer_r.ch       <= gidx;
            xfer_r.sram_adr <= xadr[gidx];
            xfer_r.per_adr  <= pad_r[gidx];
            xfer_r.sram_rd  <= gctrl.dir;
            xfer_r.byte_sz  <= gctrl.size;
            xfer_r.null_wr  <= gctrl.null_write_enable && !gctrl.dir;
            if (any_gnt)
            begin
                last_r <= xadr[gidx][15:0];
                lca_r  <= gidx;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, enable and output
    // ------------------------------------------------------------
    // Event set beats a same-cycle software clear.
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ist_r <= '0;
            ien_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            ist_r <= (ist_r & ~(wr_iclr ? wdata_in[N-1:0] : '0)) |
                     irq_ev;
            if (wr_ien)
                ien_r <= wdata_in[N-1:0];
            irq_r <= |(((ist_r & ~(wr_iclr ? wdata_in[N-1:0] : '0)) |
                       irq_ev) & (wr_ien ? wdata_in[N-1:0] : ien_r));
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped addresses read zero; clear register is write-only.
    wire [15:0] rd_shared =
        (addr_in == dcr_pkg::OFS_LAST) ? last_r :
        (addr_in == dcr_pkg::OFS_WCOL) ? 16'(wcol_r) :
        (addr_in == dcr_pkg::OFS_RCOL) ? 16'(rcol_r) :
        (addr_in == dcr_pkg::OFS_LCA)  ? 16'(lca_r) :
        (addr_in == dcr_pkg::OFS_PPS)  ? 16'(sel_r) :
        (addr_in == dcr_pkg::OFS_IST)  ? 16'(ist_r) :
        (addr_in == dcr_pkg::OFS_IEN)  ? 16'(ien_r) : 16'h0000;
    wire        ch_ok   = (ch_field < 5'(N));
    wire [15:0] rd_mux  = shared_hit ? rd_shared :
                          ch_ok ? rd_ch[ch_field[dcr_pkg::CH_W-1:0]] :
                          16'h0000;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rdata_r <= 16'h0000;
        else
            rdata_r <= rd_in ? rd_mux : 16'h0000;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata_out = rdata_r;
    assign xfer_out  = xfer_r;
    assign irq_out   = irq_r;

    // Shared writes other than interrupt registers are ignored
    wire unused_ok = wr_shared;

endmodule : dcr_dma

// *** core/dcr_pkg.sv ***
package dcr_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH = 4;      // Channels in this build
    localparam int unsigned CH_W   = 2;      // Channel index width
    localparam int unsigned ADR_W  = 8;      // Register word address
    localparam int unsigned DAT_W  = 16;     // Register data width
    localparam int unsigned SA_W   = 24;     // Start address width

    // ------------------------------------------------------------
    // Per-channel register index (address = channel*8 + index)
    // ------------------------------------------------------------
    localparam logic [2:0] OFS_CTRL = 3'h0;  // channel_control
    localparam logic [2:0] OFS_STAH = 3'h1;  // primary_start_address high
    localparam logic [2:0] OFS_STAL = 3'h2;  // primary_start_address low
    localparam logic [2:0] OFS_STBH = 3'h3;  // secondary_start_high
    localparam logic [2:0] OFS_STBL = 3'h4;  // secondary_start_low
    localparam logic [2:0] OFS_PAD  = 3'h5;  // peripheral_address
    localparam logic [2:0] OFS_CNT  = 3'h6;  // transfer_count

    // ------------------------------------------------------------
    // Shared register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_LAST = 8'h80; // last_sram_address
    localparam logic [7:0] OFS_WCOL = 8'h81; // write_collision_status
    localparam logic [7:0] OFS_RCOL = 8'h82; // request_collision_status
    localparam logic [7:0] OFS_LCA  = 8'h83; // last_active_channel
    localparam logic [7:0] OFS_PPS  = 8'h84; // pingpong_status
    localparam logic [7:0] OFS_IST  = 8'h85; // Interrupt status, RO
    localparam logic [7:0] OFS_ICLR = 8'h86; // Interrupt clear, WO
    localparam logic [7:0] OFS_IEN  = 8'h87; // Interrupt enable

    // ------------------------------------------------------------
    // Reset values, masks and encodings
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [15:0] CTRL_MASK = 16'hf833; // Writable bits
    localparam logic [15:0] LAST_RST  = 16'h0000;
    localparam logic [1:0]  AM_INC    = 2'h0; // Indirect, post-increment
    localparam logic [1:0]  AM_NOINC  = 2'h1; // Indirect, fixed
    localparam logic [1:0]  AM_PIA    = 2'h2; // Peripheral indirect
    localparam logic [SA_W-1:0] STEP_BYTE = 24'h000001;
    localparam logic [SA_W-1:0] STEP_WORD = 24'h000002;

    // Control word layout
    typedef struct packed {
        logic       en;      // channel_enable
        logic       size;    // 1 byte, 0 word
        logic       dir;     // 1 SRAM to peripheral
        logic       half;    // Interrupt at half block
        logic       null_write_enable;   // null_write_enable
        logic [4:0] rsv_a;   // Reads zero
        logic [1:0] addressing_mode;   // addressing_mode
        logic [1:0] rsv_b;   // Reads zero
        logic [1:0] mode;    // [1] ping-pong, [0] one-shot
    } dcr_ctrl_t;

    // One issued transfer
    typedef struct packed {
        logic            valid;    // Transfer issued this cycle
        logic [CH_W-1:0] ch;       // Channel granted
        logic [SA_W-1:0] sram_adr; // dual_port_sram address
        logic [15:0]     per_adr;  // Peripheral data register
        logic            sram_rd;  // 1 SRAM read/periph write
        logic            byte_sz;  // Byte transfer
        logic            null_wr;  // Extra null periph write
    } dcr_xfer_t;

endpackage : dcr_pkg

// *** verif/dcr_dma_assertions.sv ***
`timescale 1ns/1ps
module dcr_dma_assertions (
    input wire logic               ref_clk_in,
    input wire logic               reset_n_in,
    input wire logic [7:0]         addr_in,
    input wire logic [15:0]        wdata_in,
    input wire logic               wr_in,
    input wire logic               rd_in,
    input wire logic [15:0]        rdata_out,
    input wire logic [3:0]         dreq_in,
    input wire logic [15:0]        pia_adr_in,
    input wire dcr_pkg::dcr_xfer_t xfer_out,
    input wire logic               irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // A transfer, then a read of one shared register with no transfer
    // beside it, so the register cannot have moved on meanwhile
    sequence s_xfer_rd(logic [7:0] a);
        xfer_out.valid ##1 (rd_in && addr_in == a && !xfer_out.valid);
    endsequence
    a_rdata_idle: assert property (!$past(rd_in)
        |-> rdata_out == 16'h0000) else $error("read data not idle");
    a_ctrl_rsv_zero: assert property (rd_in && !addr_in[7]
        && addr_in[2:0] == dcr_pkg::OFS_CTRL
        |=> (rdata_out & ~dcr_pkg::CTRL_MASK) == 16'h0000)
        else $error("reserved control bits set");
    a_bad_ch_zero: assert property (rd_in && !addr_in[7]
        && addr_in[6:5] != 2'h0 |=> rdata_out == 16'h0000)
        else $error("absent channel read nonzero");
    a_last_addr: assert property (s_xfer_rd(dcr_pkg::OFS_LAST)
        |=> rdata_out == $past(xfer_out.sram_adr[15:0], 2))
        else $error("last address wrong");
    a_last_chan: assert property (s_xfer_rd(dcr_pkg::OFS_LCA)
        |=> rdata_out == {14'h0, $past(xfer_out.ch, 2)})
        else $error("last channel wrong");
    a_null_dir: assert property (xfer_out.valid && xfer_out.null_wr
        |-> !xfer_out.sram_rd) else $error("null write on read");
    a_irq_cause: assert property ($rose(irq_out) |-> xfer_out.valid
        || $past(xfer_out.valid) || $past(xfer_out.valid, 2)
        || $past(wr_in) || $past(wr_in, 2)) else $error("irq no cause");
    a_irq_drop: assert property ($fell(irq_out)
        |-> $past(wr_in) || $past(wr_in, 2)) else $error("irq dropped");
endmodule : dcr_dma_assertions
bind dcr_dma dcr_dma_assertions u_chk (.ref_clk_in, .reset_n_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .dreq_in,
    .pia_adr_in, .xfer_out, .irq_out);

// *** verif/dcr_periph_model.sv ***
`timescale 1ns/1ps
// Peripheral side: a request level per channel, held until served
module dcr_periph_model (
    input  wire logic               clk_in,
    input  wire logic               reset_n_in,
    input  wire logic [3:0]         fire_in,
    input  wire dcr_pkg::dcr_xfer_t xfer_in,
    output logic [3:0]              dreq_out,
    output logic [15:0]             pia_adr_out
);
    logic [3:0] req_r = 4'h0;            // Held request levels
    assign dreq_out    = req_r;
    assign pia_adr_out = 16'h0a00;       // Index for indirect mode
    // Served request drops, so the next one makes a fresh rising edge
    always @(posedge clk_in or negedge reset_n_in)
        if (!reset_n_in) req_r <= 4'h0;
        else req_r <= (req_r | fire_in)
            & ~(xfer_in.valid ? 4'h1 << xfer_in.ch : 4'h0);
endmodule : dcr_periph_model

// *** verif/dcr_dma_tb_top.sv ***
`timescale 1ns/1ps
module dcr_dma_tb_top;
    logic               clk   = 1'b0;
    logic               rst_n = 1'b0;
    logic               wr    = 1'b0;
    logic               rd    = 1'b0;
    logic [7:0]         addr  = 8'h00;
    logic [15:0]        wdata = 16'h0000;
    logic [3:0]         fire  = 4'h0;
    logic [3:0]         dreq;
    logic [15:0]        rdata;
    logic [15:0]        pia;
    logic               irq;
    dcr_pkg::dcr_xfer_t xf;
    dcr_pkg::dcr_xfer_t x;
    dcr_pkg::dcr_xfer_t q[$];            // Transfers seen, oldest first
    int                 fail_count   = 0;
    int                 total_checks = 0;
    int                 cyc          = 0;
    dcr_dma DUT (.ref_clk_in(clk), .reset_n_in(rst_n), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .dreq_in(dreq), .pia_adr_in(pia), .xfer_out(xf), .irq_out(irq));
    dcr_periph_model u_per (.clk_in(clk), .reset_n_in(rst_n),
        .fire_in(fire), .xfer_in(xf), .dreq_out(dreq), .pia_adr_out(pia));
    always #20 clk = ~clk;
    // Capture transfers; the run needs well under 4000 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (xf.valid === 1'b1) q.push_back(xf);
        if (cyc == 4000) fail_count++;
        if (cyc == 4000) tally_and_finish();
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) $display("[ERR] %0t got %h want %h", $time, g, e);
        if (g !== e) fail_count++;
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_chk
    task automatic kick(input logic [3:0] m);
        @(posedge clk) fire <= m;
        @(posedge clk) fire <= 4'h0;
    endtask : kick
    // Bounded wait for the next transfer; an empty one fails its fields
    task automatic take();
        repeat (40) if (q.size() == 0) @(posedge clk);
        x = (q.size() != 0) ? q.pop_front() : '0;
    endtask : take
    // Read a shared register in the cycle right after the transfer
    task automatic kick_rd(input logic [3:0] m, input logic [7:0] a,
                           input logic [15:0] e);
        kick(m);
        repeat (4) @(posedge clk);
        rd_chk(a, e);
        take();
    endtask : kick_rd
    task automatic setup(input logic [7:0] b, input logic [15:0] lo,
                         input logic [15:0] cnt, input logic [15:0] ctl);
        wr_reg(b + 8'h01, 16'h0000);
        wr_reg(b + 8'h02, lo);
        wr_reg(b + 8'h05, 16'h0777);
        wr_reg(b + 8'h06, cnt);
        wr_reg(b, ctl);
    endtask : setup
    task automatic t_reset();
        rd_chk(8'h00, 16'h0000);
        for (int i = 0; i < 5; i++) rd_chk(8'h80 + 8'(i), 16'h0000);
        rd_chk(8'h88, 16'h0000);
        rd_chk(8'h40, 16'h0000);
    endtask : t_reset
    task automatic t_ctrl();
        for (int i = 1; i < 4; i++) wr_reg(8'h18, 16'h0011 * 16'(i));
        rd_chk(8'h18, 16'h0033);
        wr_reg(8'h18, 16'hffff);
        rd_chk(8'h18, 16'hf833);
        wr_reg(8'h18, 16'h0000);
        wr_reg(8'h0b, 16'h0012);
        wr_reg(8'h0c, 16'h3456);
        rd_chk(8'h0b, 16'h0012);
        rd_chk(8'h0c, 16'h3456);
    endtask : t_ctrl
    task automatic t_block();
        wr_reg(8'h87, 16'h000f);
        setup(8'h00, 16'h0100, 16'h0002, 16'h8001);
        for (int i = 0; i < 3; i++)
        begin
            chk({15'h0, irq}, 16'h0000);
            kick(4'h1);
            take();
            chk(x.sram_adr[15:0], 16'h0100 + 16'(2 * i));
            chk(x.per_adr, 16'h0777);
            chk({15'h0, x.sram_rd}, 16'h0000);
        end
        rd_chk(8'h85, 16'h0001);
        chk({15'h0, irq}, 16'h0001);
        rd_chk(8'h80, 16'h0104);
        rd_chk(8'h83, 16'h0000);
        wr_reg(8'h86, 16'h000f);
        rd_chk(8'h85, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
    endtask : t_block
    // Two channels asking at once: the lower number goes first
    task automatic t_prio();
        setup(8'h08, 16'h0200, 16'h0001, 16'hc001);
        setup(8'h10, 16'h0300, 16'h0000, 16'h8001);
        kick(4'h6);
        take();
        chk({14'h0, x.ch}, 16'h0001);
        chk({15'h0, x.byte_sz}, 16'h0001);
        take();
        chk({14'h0, x.ch}, 16'h0002);
        rd_chk(8'h85, 16'h0004);
        kick(4'h2);
        take();
        chk(x.sram_adr[15:0], 16'h0201);
        rd_chk(8'h85, 16'h0006);
        rd_chk(8'h83, 16'h0001);
    endtask : t_prio
    // Ping-pong, half interrupt, null write, fixed and indirect address
    task automatic t_pingpong();
        wr_reg(8'h86, 16'h000f);
        wr_reg(8'h1b, 16'h0000);
        wr_reg(8'h1c, 16'h0500);
        setup(8'h18, 16'h0400, 16'h0001, 16'h9812);
        kick_rd(4'h8, 8'h80, 16'h0400);
        chk(x.sram_adr[15:0], 16'h0400);
        chk({15'h0, x.null_wr}, 16'h0001);
        rd_chk(8'h85, 16'h0008);
        wr_reg(8'h86, 16'h000f);
        kick_rd(4'h8, 8'h83, 16'h0003);
        chk(x.sram_adr[15:0], 16'h0400);
        rd_chk(8'h85, 16'h0000);
        rd_chk(8'h84, 16'h0008);
        rd_chk(8'h1c, 16'h0500);
        kick_rd(4'h8, 8'h80, 16'h0500);
        chk(x.sram_adr[15:0], 16'h0500);
        wr_reg(8'h18, 16'h9822);
        kick_rd(4'h8, 8'h80, 16'h0a00);
        chk(x.sram_adr[15:0], 16'h0a00);
        wr_reg(8'h18, 16'h0000);
    endtask : t_pingpong
    task automatic tally_and_finish();
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_ctrl();
        t_block();
        t_prio();
        t_pingpong();
        tally_and_finish();
    end
endmodule : dcr_dma_tb_top
